/* File: include/sensor_readout_pkg.sv */
// Constants, register map and types of the sensor readout sequencer.
// Assumes a single core clock and a plain word-addressed register port.
package sensor_readout_pkg;

  // ****************************************
  // Register port
  // ****************************************
  localparam int ADDR_W = 10;
  localparam int DATA_W = 16;
  localparam logic [9:0] REG_CTRL = 10'h000;
  localparam logic [9:0] REG_STATUS = 10'h001;
  localparam logic [9:0] REG_FRAME_CNT = 10'h002;
  localparam logic [9:0] REG_CTX_A_BASE = 10'h010;
  localparam logic [9:0] REG_CTX_B_BASE = 10'h030;
  localparam logic [9:0] REG_CTX_RAM_BASE = 10'h100;
  localparam int CTX_RAM_DEPTH = 256;

  // ****************************************
  // Control register fields
  // ****************************************
  localparam int CTRL_STREAM = 0;
  localparam int CTRL_HDR = 1;
  localparam int CTRL_SLAVE = 2;
  localparam int CTRL_GLOBAL = 3;
  localparam int CTRL_CAPTURE = 4;
  localparam int CTRL_EMB = 5;
  localparam int CTRL_STAT = 6;
  localparam int CTRL_CTX_SEL = 7;
  localparam int CTRL_MIR_H = 8;
  localparam int CTRL_MIR_V = 9;
  localparam int CTRL_HOUT_LSB = 10;
  localparam int CTRL_RATIO_LSB = 12;
  localparam int CTRL_RATIO_ROWS = 14;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [1:0] HOUT_BOTH = 2'h0;
  localparam logic [1:0] HOUT_FIRST = 2'h1;
  localparam logic [1:0] HOUT_SECOND = 2'h2;

  // ****************************************
  // Per-context field indexes and reset values
  // ****************************************
  localparam int NF = 23;
  localparam int FLD_EXP = 0;
  localparam int FLD_EXP2 = 1;
  localparam int FLD_LINE_LEN = 2;
  localparam int FLD_FRAME_LEN = 3;
  localparam int FLD_ROW_BIN = 4;
  localparam int FLD_COL_BIN = 5;
  localparam int FLD_AGAIN_2 = 6;
  localparam int FLD_AGAIN_1 = 7;
  localparam int FLD_DCG_2 = 8;
  localparam int FLD_DCG_1 = 9;
  localparam int FLD_BYPASS = 10;
  localparam int FLD_X_START = 11;
  localparam int FLD_Y_START = 12;
  localparam int FLD_X_END = 13;
  localparam int FLD_Y_END = 14;
  localparam int FLD_Y_INC = 15;
  localparam int FLD_X_INC = 16;
  localparam int FLD_GAIN_G1 = 17;
  localparam int FLD_GAIN_B = 18;
  localparam int FLD_GAIN_R = 19;
  localparam int FLD_GAIN_G2 = 20;
  localparam int FLD_GAIN_GLB = 21;
  localparam int FLD_OP_MODE = 22;
  // Index 0 sits in the low word
  localparam logic [NF-1:0][15:0] CTX_RST = {
    16'h0000, 16'h0010, 16'h0010, 16'h0010, 16'h0010, 16'h0010,
    16'h0001, 16'h0001, 16'h0445, 16'h0789, 16'h000e, 16'h000a,
    16'h0000, 16'h0000, 16'h0000, 16'h0010, 16'h0010, 16'h0000,
    16'h0000, 16'h0465, 16'h0898, 16'h0004, 16'h0010};

  // ****************************************
  // Frame structure and gain limits
  // ****************************************
  localparam logic [1:0] EMB_ROWS = 2'h2;
  localparam logic [1:0] STAT_ROWS = 2'h2;
  localparam logic [15:0] GAIN_MIN = 16'h0010;
  localparam logic [15:0] GAIN_MAX = 16'h0100;
  localparam logic [1:0] LK_BLANK = 2'h0;
  localparam logic [1:0] LK_EMB = 2'h1;
  localparam logic [1:0] LK_ACT = 2'h2;
  localparam logic [1:0] LK_STAT = 2'h3;

  typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_FRAME} readout_state_e;

endpackage

/* File: verilog/sensor_readout_ctrl.sv */
// Readout sequencer: frame/line timing, HDR interleave, contexts, gains.
// Assumes the register master keeps the strobe protocol and a 40 MHz core clock.
//
// What this block does
// - Default window makes the first output pixel column 10, row 14.
// - Mirrored readout shifts by one so the first pixel keeps its colour.
// - Rows are read one after another, columns in fixed order within a row.
// - Linear single exposure after reset; HDR only when the control bit is set.
// - HDR keeps two reset pointers and one read pointer pair per rolling readout.
// - Exposure ratio selectable as 4, 8, 16 or 32.
// - Alternatively second exposure uses its own programmed row count.
// - HDR emits line-interleaved exposures, or only the first, or only the second.
// - Rolling mode resets then reads each row, frames back to back while streaming outside slave mode.
// - Exposure is reset-to-read row distance, equal for every row of a frame.
// - Exposure changes take effect only at a frame boundary.
// - Global reset single capture drives the mechanical shutter control.
// - Optional two embedded data rows precede the first active row.
// - Optional two statistics rows follow the last active row.
// - Slave mode starts each frame on the external trigger input.
// - 256 x 16 context memory writable and readable by the host.
// - One select bit chooses between two full register sets.
// - After a select change, exposure follows at n+1, everything else at n+2.
// - Both sets hold exposures, timing, binning, gains, window, increments, mode.
// - Analog gain 1.0 to 16 applies to all colours, linear and HDR.
// - Digital gain 1 to 16 programmable per colour channel.
// - In interleaved mode each exposure uses its own analog gain.
//
// The register offsets and the strobed register port were chosen for this implementation.
module sensor_readout_ctrl
  import sensor_readout_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic i_arst_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr_en,
  input wire logic i_rd_en,
  input wire logic i_frame_trigger,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_frame_valid,
  output logic o_line_valid,
  output logic o_frame_start,
  output logic [1:0] o_line_kind,
  output logic [15:0] o_row_addr,
  output logic [15:0] o_col_addr,
  output logic o_exp_sel,
  output logic [15:0] o_analog_gain,
  output logic [15:0] o_digital_gain,
  output logic [15:0] o_global_gain,
  output logic o_conv_gain_hi,
  output logic [1:0] o_bin_mode,
  output logic [15:0] o_rst1_row,
  output logic o_rst1_en,
  output logic [15:0] o_rst2_row,
  output logic o_rst2_en,
  output logic o_global_reset,
  output logic o_shutter_open
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [15:0] ctrl;
    logic [1:0][NF-1:0][15:0] ctx;
    logic exp_ctx;
    logic oth_ctx;
    logic single;
    logic [15:0] e1;
    logic [15:0] e2;
    readout_state_e state;
    logic [15:0] col;
    logic [15:0] line;
    logic [15:0] xcur;
    logic [15:0] ycur;
    logic [15:0] integ;
    logic [1:0] kind;
    logic [1:0] rcnt;
    logic sub;
    logic px_on;
    logic trig_s0;
    logic trig_s1;
    logic trig_s2;
    logic trig_lvl;
    logic [15:0] frame_cnt;
    logic [15:0] rdata;
    logic fv;
    logic lv;
    logic fstart;
    logic [15:0] row_o;
    logic [15:0] col_o;
    logic [15:0] again;
    logic [15:0] dgain;
    logic [15:0] ggain;
    logic cg;
    logic [1:0] bin;
    logic [15:0] rst1_row;
    logic rst1_en;
    logic [15:0] rst2_row;
    logic rst2_en;
    logic grst;
    logic shutter;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic [15:0] ctx_ram [CTX_RAM_DEPTH];

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] next_addr(input logic [15:0] a, input logic [15:0] inc);
    if (inc == 16'h0003 && a[0])
      return a + 16'h0003;
    return a + 16'h0001;
  endfunction

  function automatic logic [15:0] mirror(input logic [15:0] a, input logic [15:0] s,
                                         input logic [15:0] e);
    return e + {15'h0, e[0] ^ s[0]} - (a - s);
  endfunction

  function automatic logic [15:0] clamp_gain(input logic [15:0] g);
    if (g < GAIN_MIN)
      return GAIN_MIN;
    if (g > GAIN_MAX)
      return GAIN_MAX;
    return g;
  endfunction

  function automatic logic [15:0] wrap_row(input logic [15:0] y, input logic [15:0] e,
                                           input logic [15:0] ys, input logic [15:0] ye);
    logic [15:0] r;
    r = y + e;
    if (r > ye)
      r = r - (ye - ys + 16'h0001);
    return r;
  endfunction

  function automatic logic [15:0] exp2_rows(input logic [15:0] e, input logic [15:0] c,
                                            input logic [15:0] rows);
    logic [15:0] r;
    if (c[CTRL_RATIO_ROWS])
      r = rows;
    else
      r = e >> (5'h02 + {3'h0, c[CTRL_RATIO_LSB +: 2]});
    if (r == 16'h0000)
      r = 16'h0001;
    return r;
  endfunction

  function automatic logic ctx_hit(input logic [9:0] a, input logic [9:0] base);
    return (a >= base) && (a < base + 10'(NF));
  endfunction

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    logic [NF-1:0][15:0] xs;
    logic [NF-1:0][15:0] ws;
    logic [9:0] off;
    logic filt;
    logic trig_edge;
    logic start;
    logic line_begin;
    logic new_row;
    logic [15:0] nx;
    logic [15:0] ny;
    logic [1:0] hout;
    logic hdr;
    st_nxt = st_r;
    xs = st_r.ctx[st_r.ctrl[CTRL_CTX_SEL]];
    ws = st_r.ctx[st_r.oth_ctx];
    off = 10'h000;
    start = 1'b0;
    line_begin = 1'b0;
    new_row = 1'b0;
    nx = 16'h0000;
    ny = 16'h0000;
    filt = 1'b0;
    trig_edge = 1'b0;
    hout = st_r.ctrl[CTRL_HOUT_LSB +: 2];
    hdr = st_r.ctrl[CTRL_HDR];
    st_nxt.fstart = 1'b0;
    st_nxt.grst = 1'b0;
    st_nxt.rst1_en = 1'b0;
    st_nxt.rst2_en = 1'b0;

    // Trigger pin: three flops, change taken once stages two and three agree
    st_nxt.trig_s0 = i_frame_trigger;
    st_nxt.trig_s1 = st_r.trig_s0;
    st_nxt.trig_s2 = st_r.trig_s1;
    filt = (st_r.trig_s1 == st_r.trig_s2) ? st_r.trig_s2 : st_r.trig_lvl;
    st_nxt.trig_lvl = filt;
    trig_edge = filt & ~st_r.trig_lvl;

    // Sequencer
    case (st_r.state)
      ST_IDLE:
      begin
        if (st_r.ctrl[CTRL_STREAM] && !st_r.ctrl[CTRL_GLOBAL])
        begin
          start = !st_r.ctrl[CTRL_SLAVE] || trig_edge;
          st_nxt.single = 1'b0;
        end
        else if (st_r.ctrl[CTRL_GLOBAL] && st_r.ctrl[CTRL_CAPTURE])
        begin
          st_nxt.ctrl[CTRL_CAPTURE] = 1'b0;
          st_nxt.grst = 1'b1;
          st_nxt.shutter = 1'b1;
          st_nxt.integ = 16'h0000;
          st_nxt.col = 16'h0000;
          st_nxt.state = ST_INTEG;
        end
      end
      ST_INTEG:
      begin
        st_nxt.col = st_r.col + 16'h0001;
        if (st_r.col >= xs[FLD_LINE_LEN] - 16'h0001)
        begin
          st_nxt.col = 16'h0000;
          st_nxt.integ = st_r.integ + 16'h0001;
          if (st_r.integ + 16'h0001 >= xs[FLD_EXP])
          begin
            st_nxt.shutter = 1'b0;
            st_nxt.single = 1'b1;
            start = 1'b1;
          end
        end
      end
      ST_FRAME:
      begin
        st_nxt.col = st_r.col + 16'h0001;
        if (st_r.px_on)
        begin
          nx = next_addr(st_r.xcur, ws[FLD_X_INC]);
          if (nx > ws[FLD_X_END])
            st_nxt.px_on = 1'b0;
          else
            st_nxt.xcur = nx;
        end
        if (st_r.col >= ws[FLD_LINE_LEN] - 16'h0001)
        begin
          st_nxt.line = st_r.line + 16'h0001;
          line_begin = 1'b1;
          if (st_r.line >= ws[FLD_FRAME_LEN] - 16'h0001)
          begin
            line_begin = 1'b0;
            st_nxt.frame_cnt = st_r.frame_cnt + 16'h0001;
            st_nxt.px_on = 1'b0;
            st_nxt.state = ST_IDLE;
            if (!st_r.single && st_r.ctrl[CTRL_STREAM] && !st_r.ctrl[CTRL_SLAVE] &&
                !st_r.ctrl[CTRL_GLOBAL])
              start = 1'b1;
          end
          else
          begin
            case (st_r.kind)
              LK_EMB:
              begin
                st_nxt.rcnt = st_r.rcnt + 2'h1;
                if (st_r.rcnt == EMB_ROWS - 2'h1)
                begin
                  st_nxt.kind = LK_ACT;
                  st_nxt.ycur = ws[FLD_Y_START];
                  new_row = 1'b1;
                end
              end
              LK_ACT:
              begin
                if (hdr && hout == HOUT_BOTH && !st_r.sub)
                  st_nxt.sub = 1'b1;
                else
                begin
                  ny = next_addr(st_r.ycur, ws[FLD_Y_INC]);
                  if (ny > ws[FLD_Y_END])
                  begin
                    st_nxt.kind = st_r.ctrl[CTRL_STAT] ? LK_STAT : LK_BLANK;
                    st_nxt.rcnt = 2'h0;
                  end
                  else
                  begin
                    st_nxt.ycur = ny;
                    new_row = 1'b1;
                  end
                end
              end
              LK_STAT:
              begin
                st_nxt.rcnt = st_r.rcnt + 2'h1;
                if (st_r.rcnt == STAT_ROWS - 2'h1)
                  st_nxt.kind = LK_BLANK;
              end
              default:
                st_nxt.kind = LK_BLANK;
            endcase
          end
        end
      end
      default:
        st_nxt.state = ST_IDLE;
    endcase

    // Frame start: exposure from the selected set now, the rest one frame later
    if (start)
    begin
      st_nxt.state = ST_FRAME;
      st_nxt.fstart = 1'b1;
      st_nxt.exp_ctx = st_r.ctrl[CTRL_CTX_SEL];
      st_nxt.oth_ctx = st_r.exp_ctx;
      st_nxt.e1 = xs[FLD_EXP];
      st_nxt.e2 = exp2_rows(xs[FLD_EXP], st_r.ctrl, xs[FLD_EXP2]);
      st_nxt.line = 16'h0000;
      st_nxt.rcnt = 2'h0;
      st_nxt.kind = st_r.ctrl[CTRL_EMB] ? LK_EMB : LK_ACT;
      new_row = !st_r.ctrl[CTRL_EMB];
      line_begin = 1'b1;
    end

    // Line start, using the set in force for the new frame
    ws = st_nxt.ctx[st_nxt.oth_ctx];
    if (line_begin)
    begin
      st_nxt.col = 16'h0000;
      st_nxt.xcur = ws[FLD_X_START];
      st_nxt.px_on = (st_nxt.kind != LK_BLANK);
      if (new_row)
      begin
        st_nxt.sub = hdr && hout == HOUT_SECOND;
        if (start)
          st_nxt.ycur = ws[FLD_Y_START];
        st_nxt.rst1_row = wrap_row(st_nxt.ycur, st_nxt.e1, ws[FLD_Y_START],
                                   ws[FLD_Y_END]);
        st_nxt.rst1_en = !st_nxt.single;
        st_nxt.rst2_row = wrap_row(st_nxt.ycur, st_nxt.e2, ws[FLD_Y_START],
                                   ws[FLD_Y_END]);
        st_nxt.rst2_en = !st_nxt.single && hdr;
      end
    end

    // Output stage
    st_nxt.fv = st_nxt.state == ST_FRAME;
    st_nxt.lv = st_nxt.fv && st_nxt.px_on && st_nxt.kind != LK_BLANK;
    st_nxt.col_o = st_r.ctrl[CTRL_MIR_H] ?
      mirror(st_nxt.xcur, ws[FLD_X_START], ws[FLD_X_END]) : st_nxt.xcur;
    st_nxt.row_o = st_r.ctrl[CTRL_MIR_V] ?
      mirror(st_nxt.ycur, ws[FLD_Y_START], ws[FLD_Y_END]) : st_nxt.ycur;
    st_nxt.again = clamp_gain(st_nxt.sub ? ws[FLD_AGAIN_2] : ws[FLD_AGAIN_1]);
    case ({st_nxt.row_o[0], st_nxt.col_o[0]})
      2'h0: st_nxt.dgain = clamp_gain(ws[FLD_GAIN_G1]);
      2'h1: st_nxt.dgain = clamp_gain(ws[FLD_GAIN_R]);
      2'h2: st_nxt.dgain = clamp_gain(ws[FLD_GAIN_B]);
      default: st_nxt.dgain = clamp_gain(ws[FLD_GAIN_G2]);
    endcase
    st_nxt.ggain = clamp_gain(ws[FLD_GAIN_GLB]);
    st_nxt.cg = st_nxt.sub ? ws[FLD_DCG_2][0] : ws[FLD_DCG_1][0];
    st_nxt.bin = {ws[FLD_ROW_BIN][0], ws[FLD_COL_BIN][0]};

    // Register writes; a host write lands after hardware updates
    if (i_wr_en)
    begin
      if (i_addr == REG_CTRL)
        st_nxt.ctrl = i_wdata;
      else if (ctx_hit(i_addr, REG_CTX_A_BASE))
      begin
        off = i_addr - REG_CTX_A_BASE;
        st_nxt.ctx[0][off[4:0]] = i_wdata;
      end
      else if (ctx_hit(i_addr, REG_CTX_B_BASE))
      begin
        off = i_addr - REG_CTX_B_BASE;
        st_nxt.ctx[1][off[4:0]] = i_wdata;
      end
    end

    // Leaving HDR drops the second exposure at once
    if (!st_nxt.ctrl[CTRL_HDR])
    begin
      st_nxt.sub = 1'b0;
      st_nxt.rst2_en = 1'b0;
    end

    // Register reads, data in the next cycle only
    st_nxt.rdata = 16'h0000;
    if (i_rd_en)
    begin
      if (i_addr == REG_CTRL)
        st_nxt.rdata = st_r.ctrl;
      else if (i_addr == REG_STATUS)
        st_nxt.rdata = {11'h000, st_r.oth_ctx, st_r.exp_ctx, st_r.shutter,
                        st_r.state != ST_IDLE, st_r.fv};
      else if (i_addr == REG_FRAME_CNT)
        st_nxt.rdata = st_r.frame_cnt;
      else if (ctx_hit(i_addr, REG_CTX_A_BASE))
      begin
        off = i_addr - REG_CTX_A_BASE;
        st_nxt.rdata = st_r.ctx[0][off[4:0]];
      end
      else if (ctx_hit(i_addr, REG_CTX_B_BASE))
      begin
        off = i_addr - REG_CTX_B_BASE;
        st_nxt.rdata = st_r.ctx[1][off[4:0]];
      end
      else if (i_addr[9:8] == REG_CTX_RAM_BASE[9:8])
        st_nxt.rdata = ctx_ram[i_addr[7:0]];
    end
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
    begin
      st_r <= '0;
      st_r.ctrl <= CTRL_RST;
      st_r.ctx <= {CTX_RST, CTX_RST};
      // Gains idle at unity, never below range
      st_r.again <= GAIN_MIN;
      st_r.dgain <= GAIN_MIN;
      st_r.ggain <= GAIN_MIN;
    end
    else
      st_r <= st_nxt;
  end

  // ****************************************
  // Context memory
  // ****************************************
  always_ff @(posedge i_core_clk)
  begin
    if (i_wr_en && i_addr[9:8] == REG_CTX_RAM_BASE[9:8])
      ctx_ram[i_addr[7:0]] <= i_wdata;
  end

  assign o_rdata = st_r.rdata;
  assign o_frame_valid = st_r.fv;
  assign o_line_valid = st_r.lv;
  assign o_frame_start = st_r.fstart;
  assign o_line_kind = st_r.kind;
  assign o_row_addr = st_r.row_o;
  assign o_col_addr = st_r.col_o;
  assign o_exp_sel = st_r.sub;
  assign o_analog_gain = st_r.again;
  assign o_digital_gain = st_r.dgain;
  assign o_global_gain = st_r.ggain;
  assign o_conv_gain_hi = st_r.cg;
  assign o_bin_mode = st_r.bin;
  assign o_rst1_row = st_r.rst1_row;
  assign o_rst1_en = st_r.rst1_en;
  assign o_rst2_row = st_r.rst2_row;
  assign o_rst2_en = st_r.rst2_en;
  assign o_global_reset = st_r.grst;
  assign o_shutter_open = st_r.shutter;

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (!i_arst_n);

  a_first_col_start: assert property ($rose(o_line_valid) && !st_r.ctrl[CTRL_MIR_H]
    |-> o_col_addr == st_r.ctx[st_r.oth_ctx][FLD_X_START])
    else $error("line does not start at window start column");
  a_mirror_colour: assert property ($rose(o_line_valid)
    |-> o_col_addr[0] == st_r.ctx[st_r.oth_ctx][FLD_X_START][0])
    else $error("mirrored line starts on wrong colour");
  a_linear_single: assert property (!st_r.ctrl[CTRL_HDR] |-> !o_rst2_en && !o_exp_sel)
    else $error("second exposure active in linear mode");
  a_hdr_pair: assert property (o_rst2_en |-> o_rst1_en && st_r.ctrl[CTRL_HDR])
    else $error("second reset pointer without first");
  a_exp_stable: assert property (o_frame_valid && !o_frame_start
    |-> $stable(st_r.e1) && $stable(st_r.e2))
    else $error("exposure changed inside a frame");
  a_ctx_takeover: assert property (o_frame_start
    |-> st_r.oth_ctx == $past(st_r.exp_ctx) && st_r.exp_ctx == $past(st_r.ctrl[CTRL_CTX_SEL]))
    else $error("context takeover order wrong");
  a_emb_first: assert property (o_frame_start && st_r.ctrl[CTRL_EMB]
    |-> o_line_kind == LK_EMB ##1 o_line_kind == LK_EMB)
    else $error("frame does not open with embedded rows");
  a_shutter_end: assert property ($fell(o_shutter_open) |-> o_frame_start && st_r.single)
    else $error("shutter closed without starting readout");
  a_gain_range: assert property (o_analog_gain >= GAIN_MIN && o_analog_gain <= GAIN_MAX
    && o_digital_gain >= GAIN_MIN && o_digital_gain <= GAIN_MAX)
    else $error("gain outside range");
  a_slave_start: assert property (o_frame_start && st_r.ctrl[CTRL_SLAVE] && !st_r.single
    |-> $past(st_r.state) == ST_IDLE)
    else $error("slave frame started without waiting");

  c_hdr_frame: cover property (o_frame_start && st_r.ctrl[CTRL_HDR]);
  c_global_capture: cover property ($fell(o_shutter_open));
  c_ctx_switch: cover property (o_frame_start && st_r.exp_ctx != st_r.oth_ctx);
  c_stats_row: cover property (o_line_kind == LK_STAT && o_line_valid);

endmodule

/* File: tb/reg_host.sv */
// Register master and trigger source facing the readout sequencer.
// Assumes tasks are called from the bench's own clocked sequence.
module reg_host
  import sensor_readout_pkg::*;
(
  input wire logic i_core_clk,
  input wire logic [DATA_W-1:0] i_rdata,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_wdata,
  output logic o_wr_en,
  output logic o_rd_en,
  output logic o_trigger
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    o_addr = '0;
    o_wdata = '0;
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_trigger = 1'b0;
  end

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr_en <= 1'b1;
    @(posedge i_core_clk);
    o_wr_en <= 1'b0;
    o_addr <= ~a;
    o_wdata <= ~d;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge i_core_clk);
    o_addr <= a;
    o_rd_en <= 1'b1;
    @(posedge i_core_clk);
    o_rd_en <= 1'b0;
    o_addr <= ~a;
    #1 d = i_rdata;
  endtask

  task automatic trig;
    @(posedge i_core_clk);
    o_trigger <= 1'b1;
    repeat (6) @(posedge i_core_clk);
    o_trigger <= 1'b0;
  endtask
endmodule

/* File: tb/tb.sv */
// Self-checking bench for the readout sequencer.
// Assumes reg_host drives the register port and the trigger pin.
module tb
  import sensor_readout_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; \
  $display("Error %s expected %0h seen %0h", n, e, g); end end

  logic clk;
  logic arst_n;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] wdata, rdata, rv;
  logic wr_en, rd_en, trig, fstart, lv, lv_d, esel, fv, grst, shut;
  logic [1:0] kind;
  logic [15:0] row, col, ctrl;
  int fail_count, n_checks, a, g_cyc;
  int cyc = 0;
  int fs_q[$];
  logic [18:0] ln_q[$];
  logic [DATA_W-1:0] ram_v[8];
  logic [ADDR_W-1:0] ram_a[8];
  int cfg_f[5] = '{FLD_LINE_LEN, FLD_FRAME_LEN, FLD_X_END, FLD_Y_END, FLD_EXP};
  logic [15:0] cfg_v[5] = '{16'h0028, 16'h001e, 16'h0011, 16'h0011, 16'h0002};

  sensor_readout_ctrl uut (.i_core_clk(clk), .i_arst_n(arst_n), .i_addr(addr),
    .i_wdata(wdata), .i_wr_en(wr_en), .i_rd_en(rd_en), .i_frame_trigger(trig),
    .o_rdata(rdata), .o_frame_valid(fv), .o_line_valid(lv), .o_frame_start(fstart),
    .o_line_kind(kind), .o_row_addr(row), .o_col_addr(col), .o_exp_sel(esel),
    .o_analog_gain(), .o_digital_gain(), .o_global_gain(), .o_conv_gain_hi(),
    .o_bin_mode(), .o_rst1_row(), .o_rst1_en(), .o_rst2_row(), .o_rst2_en(),
    .o_global_reset(grst), .o_shutter_open(shut));
  reg_host host (.i_core_clk(clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata),
    .o_wr_en(wr_en), .o_rd_en(rd_en), .o_trigger(trig));

  // *****
  // Line and frame monitor
  // *****
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    lv_d <= lv;
    if (fstart === 1'b1) fs_q.push_back(cyc);
    if (grst === 1'b1 && shut === 1'b1) g_cyc <= cyc;
    if (lv === 1'b1 && lv_d !== 1'b1) ln_q.push_back({esel, kind, row[7:0], col[7:0]});
  end

  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic wait_fs(input int lim);
    int k;
    for (k = 0; k < lim; k++)
    begin
      @(posedge clk);
      #1;
      if (fstart === 1'b1) break;
    end
    if (k == lim)
    begin
      fail_count++;
      close_out();
    end
  endtask

  task automatic check_frame(input int per, input logic sel);
    a = 0;
    `CHK("lines", 4 + 4 * per, ln_q.size())
    foreach (ln_q[j])
    begin
      if (j < 2 || j >= ln_q.size() - 2)
        `CHK("kind", j < 2 ? LK_EMB : LK_STAT, ln_q[j][17:16])
      else
      begin
        `CHK("act", LK_ACT, ln_q[j][17:16])
        `CHK("row", 8'(14 + a / per), ln_q[j][15:8])
        `CHK("col", 8'h0a, ln_q[j][7:0])
        `CHK("sel", per == 2 ? a[0] : sel, ln_q[j][18])
        a++;
      end
    end
  endtask

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    arst_n = 1'b0;
    a = $urandom(32'hebd6);
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    host.rd(REG_CTRL, rv);
    `CHK("ctrl", CTRL_RST, rv)
    for (int i = 0; i < NF; i++)
    begin
      host.rd(REG_CTX_A_BASE + 10'(i), rv);
      `CHK("set a", CTX_RST[i], rv)
      host.rd(REG_CTX_B_BASE + 10'(i), rv);
      `CHK("set b", CTX_RST[i], rv)
    end
    for (int i = 0; i < 8; i++)
    begin
      ram_a[i] = REG_CTX_RAM_BASE + 10'(i * 32 + $urandom_range(31));
      ram_v[i] = 16'($urandom);
      host.wr(ram_a[i], ram_v[i]);
    end
    for (int i = 0; i < 8; i++)
    begin
      host.rd(ram_a[i], rv);
      `CHK("ctx ram", ram_v[i], rv)
    end
    host.rd(10'h3ff, rv);
    `CHK("unmapped", 16'h0000, rv)
    foreach (cfg_f[i])
    begin
      host.wr(REG_CTX_A_BASE + 10'(cfg_f[i]), cfg_v[i]);
      host.wr(REG_CTX_B_BASE + 10'(cfg_f[i]), cfg_v[i]);
    end
    host.wr(REG_CTX_B_BASE + 10'(FLD_LINE_LEN), 16'h0032);
    // Linear stream with embedded and statistics rows
    host.wr(REG_CTRL, 16'h0061);
    wait_fs(100);
    wait_fs(1300);
    ln_q.delete();
    wait_fs(1300);
    check_frame(1, 1'b0);
    `CHK("period", 1200, fs_q[$] - fs_q[$-1])
    // HDR output: both, first only, second only
    for (int m = 0; m < 3; m++)
    begin
      ctrl = {4'h0, 2'(m), 10'h063};
      host.wr(REG_CTRL, ctrl);
      wait_fs(1300);
      ln_q.delete();
      wait_fs(1300);
      check_frame(m == 0 ? 2 : 1, m == 2);
    end
    // Select set b in mid frame
    host.wr(REG_CTRL, 16'h00e1);
    repeat (3) wait_fs(1600);
    repeat (2) @(posedge clk);
    `CHK("frame n+1", 1200, fs_q[$-1] - fs_q[$-2])
    `CHK("frame n+2", 1500, fs_q[$] - fs_q[$-1])
    // Slave mode waits for the trigger, mirrored readout
    host.wr(REG_CTRL, 16'h0305);
    a = fs_q.size();
    repeat (1600) @(posedge clk);
    `CHK("no trigger", a, fs_q.size())
    `CHK("idle fv", 1'b0, fv)
    ln_q.delete();
    host.trig();
    repeat (8) @(posedge clk);
    `CHK("triggered", a + 1, fs_q.size())
    `CHK("busy fv", 1'b1, fv)
    `CHK("mirror", 16'h1212, ln_q[0][15:0])
    // Global reset capture, shutter held for the exposure
    host.wr(REG_CTRL, 16'h0018);
    wait_fs(1700);
    repeat (2) @(posedge clk);
    `CHK("exposure", 32'(cfg_v[4] * cfg_v[0]), fs_q[$] - g_cyc)
    `CHK("shutter", 1'b0, shut)
    close_out();
  end
endmodule
